// File: rtl/tltc_pkg.sv
// Constants, field layouts and reset values for the thermal loop timing configuration bank.
// Assumes an 8-bit register port with byte addresses as used by the host serial management bus.
package tltc_pkg;
	localparam logic [7:0]  TLTC_CYCLE_ADDR      = 8'h0c;
	localparam logic [7:0]  TLTC_THERM_ADDR      = 8'h0d;
	localparam logic [7:0]  TLTC_CYCLE_RESET     = 8'h40;
	localparam logic [7:0]  TLTC_THERM_RESET     = 8'h00;
	localparam logic [7:0]  TLTC_CYCLE_WMASK     = 8'h7f;
	localparam logic [7:0]  TLTC_READ_UNMAPPED   = 8'h00;
	localparam int          TLTC_R1_CODE_LSB     = 0;
	localparam int          TLTC_R2_CODE_LSB     = 3;
	localparam int          TLTC_LOOP_SEL_BIT    = 6;
	localparam int          TLTC_BOOST1_DIS_BIT  = 0;
	localparam int          TLTC_BOOST2_DIS_BIT  = 1;
	localparam int          TLTC_WIN1_LSB        = 2;
	localparam int          TLTC_WIN2_LSB        = 5;
	localparam int          TLTC_CODE_W          = 3;
	localparam int          TLTC_PERIOD_W        = 12;
	localparam int          TLTC_WIN_W           = 6;
	localparam logic [11:0] TLTC_DEC_BASE_CYC    = 12'h008;
	localparam logic [11:0] TLTC_INC_BASE_CYC    = 12'h010;
	localparam logic [2:0]  TLTC_WIN_MAX_CODE    = 3'h5;
	localparam logic [5:0]  TLTC_WIN_BASE_QUARTS = 6'h01;
	localparam logic [11:0] TLTC_PERIOD_IDLE     = 12'h000;
	localparam logic [5:0]  TLTC_WIN_IDLE        = 6'h00;

	typedef enum logic {
		TLTC_LOOP_LEGACY,
		TLTC_LOOP_CURRENT
	} tltc_loop_t;

	// Window length in quarter seconds; codes above the top step saturate at 8 s.
	function automatic logic [5:0] tltc_win_quarters(input logic [2:0] code);
		logic [2:0] c;
		c = (code > TLTC_WIN_MAX_CODE) ? TLTC_WIN_MAX_CODE : code;
		return TLTC_WIN_BASE_QUARTS << c;
	endfunction : tltc_win_quarters
endpackage : tltc_pkg

// File: rtl/tltc_period_decode.sv
// Decodes one remote channel cycle code into decrease and increase periods.
// Assumes code comes from a register in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module tltc_period_decode
	import tltc_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire logic [TLTC_CODE_W-1:0]   code,
	input  wire logic                     dyn_en,
	output logic                          period_valid,
	output logic      [TLTC_PERIOD_W-1:0] dec_cycles,
	output logic      [TLTC_PERIOD_W-1:0] inc_cycles
);
	logic                     valid_ff;
	logic [TLTC_PERIOD_W-1:0] dec_ff;
	logic [TLTC_PERIOD_W-1:0] inc_ff;
	logic [TLTC_PERIOD_W-1:0] nxt_dec;
	logic [TLTC_PERIOD_W-1:0] nxt_inc;

	always_comb begin
		nxt_dec = TLTC_PERIOD_IDLE;
		nxt_inc = TLTC_PERIOD_IDLE;
		if (dyn_en) begin
			nxt_dec = TLTC_DEC_BASE_CYC << code;
			nxt_inc = TLTC_INC_BASE_CYC << code;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			valid_ff <= 1'b0;
			dec_ff   <= TLTC_PERIOD_IDLE;
			inc_ff   <= TLTC_PERIOD_IDLE;
		end else if (ce) begin
			valid_ff <= dyn_en;
			dec_ff   <= nxt_dec;
			inc_ff   <= nxt_inc;
		end
	end

	assign period_valid = valid_ff;
	assign dec_cycles   = dec_ff;
	assign inc_cycles   = inc_ff;
endmodule : tltc_period_decode
`default_nettype wire

// File: rtl/tltc_top.sv
// Register bank for dynamic minimum-temperature cycle timing, loop select and thermal-limit pin boost/windows.
// Assumes a serial bus front end that delivers single-cycle byte read and write strobes, and comparators
// that report over-limit levels already qualified by their channel enables.
`timescale 1ns/1ps
`default_nettype none
module tltc_top
	import tltc_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire logic                     sw_reset,
	input  wire logic                     reg_lock,
	input  wire logic [7:0]               reg_addr,
	input  wire logic                     reg_wr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	input  wire logic                     remote_one_dyn_en,
	input  wire logic                     remote_two_dyn_en,
	input  wire logic                     first_over_limit,
	input  wire logic                     second_over_limit,
	input  wire logic                     first_timer_en,
	input  wire logic                     second_timer_en,
	input  wire logic                     first_thermal_limit_pin_i,
	output logic                          first_thermal_limit_pin_o,
	output logic                          first_thermal_limit_pin_oe_n,
	input  wire logic                     second_thermal_limit_pin_i,
	output logic                          second_thermal_limit_pin_o,
	output logic                          second_thermal_limit_pin_oe_n,
	output logic                          fan_max_pwm,
	output logic                          loop_current,
	output logic                          remote_one_period_valid,
	output logic      [TLTC_PERIOD_W-1:0] remote_one_dec_cycles,
	output logic      [TLTC_PERIOD_W-1:0] remote_one_inc_cycles,
	output logic                          remote_two_period_valid,
	output logic      [TLTC_PERIOD_W-1:0] remote_two_dec_cycles,
	output logic      [TLTC_PERIOD_W-1:0] remote_two_inc_cycles,
	output logic                          first_timer_run,
	output logic      [TLTC_WIN_W-1:0]    first_timer_quarters,
	output logic                          second_timer_run,
	output logic      [TLTC_WIN_W-1:0]    second_timer_quarters,
	output logic                          first_pin_seen_low,
	output logic                          second_pin_seen_low
);
	logic [7:0]            cycle_ff;
	logic [7:0]            therm_ff;
	logic [7:0]            rdata_ff;
	logic                  drive1_ff;
	logic                  drive2_ff;
	logic                  fan_max_ff;
	logic                  run1_ff;
	logic                  run2_ff;
	logic [TLTC_WIN_W-1:0] win1_ff;
	logic [TLTC_WIN_W-1:0] win2_ff;
	logic                  seen1_ff;
	logic                  seen2_ff;
	logic [7:0]            nxt_rdata;
	logic                  wr_ok;
	tltc_loop_t            loop_sel;

	// Boost is wanted while a pin is driven and its disable bit is clear.
	function automatic logic tltc_boost_req(input logic over, input logic boost_dis);
		return over && !boost_dis;
	endfunction : tltc_boost_req

	// A disabled timer reports an idle window so no measurement can start from a stale code.
	function automatic logic [TLTC_WIN_W-1:0] tltc_timer_window(input logic en, input logic [TLTC_CODE_W-1:0] code);
		return en ? tltc_win_quarters(code) : TLTC_WIN_IDLE;
	endfunction : tltc_timer_window

	// Writes are dropped entirely while the lock is set.
	assign wr_ok = reg_wr && !reg_lock;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cycle_ff <= TLTC_CYCLE_RESET;
		end else if (ce) begin
			if (sw_reset) begin
				cycle_ff <= TLTC_CYCLE_RESET;
			end else if (wr_ok && reg_addr == TLTC_CYCLE_ADDR) begin
				cycle_ff <= reg_wdata & TLTC_CYCLE_WMASK;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			therm_ff <= TLTC_THERM_RESET;
		end else if (ce) begin
			if (sw_reset) begin
				therm_ff <= TLTC_THERM_RESET;
			end else if (wr_ok && reg_addr == TLTC_THERM_ADDR) begin
				therm_ff <= reg_wdata;
			end
		end
	end

	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			unique case (reg_addr)
				TLTC_CYCLE_ADDR: nxt_rdata = cycle_ff & TLTC_CYCLE_WMASK;
				TLTC_THERM_ADDR: nxt_rdata = therm_ff;
				default:         nxt_rdata = TLTC_READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= TLTC_READ_UNMAPPED;
		end else if (ce) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Each pin is pulled low for as long as its over-limit level is seen.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			drive1_ff <= 1'b0;
			drive2_ff <= 1'b0;
		end else if (ce) begin
			drive1_ff <= first_over_limit;
			drive2_ff <= second_over_limit;
		end
	end

	// Boost shares the pin drive's edge, so the fans rise together with the pin and not a cycle later.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fan_max_ff <= 1'b0;
		end else if (ce) begin
			fan_max_ff <= tltc_boost_req(first_over_limit, therm_ff[TLTC_BOOST1_DIS_BIT])
				|| tltc_boost_req(second_over_limit, therm_ff[TLTC_BOOST2_DIS_BIT]);
		end
	end

	// The wire level is sampled so that a low forced by another device is reported as well.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			seen1_ff <= 1'b0;
			seen2_ff <= 1'b0;
		end else if (ce) begin
			seen1_ff <= !first_thermal_limit_pin_i;
			seen2_ff <= !second_thermal_limit_pin_i;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run1_ff <= 1'b0;
			win1_ff <= TLTC_WIN_IDLE;
		end else if (ce) begin
			run1_ff <= first_timer_en;
			win1_ff <= tltc_timer_window(first_timer_en, therm_ff[TLTC_WIN1_LSB +: TLTC_CODE_W]);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run2_ff <= 1'b0;
			win2_ff <= TLTC_WIN_IDLE;
		end else if (ce) begin
			run2_ff <= second_timer_en;
			win2_ff <= tltc_timer_window(second_timer_en, therm_ff[TLTC_WIN2_LSB +: TLTC_CODE_W]);
		end
	end

	tltc_period_decode u_remote_one (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.ce           (ce),
		.code         (cycle_ff[TLTC_R1_CODE_LSB +: TLTC_CODE_W]),
		.dyn_en       (remote_one_dyn_en),
		.period_valid (remote_one_period_valid),
		.dec_cycles   (remote_one_dec_cycles),
		.inc_cycles   (remote_one_inc_cycles)
	);

	tltc_period_decode u_remote_two (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.ce           (ce),
		.code         (cycle_ff[TLTC_R2_CODE_LSB +: TLTC_CODE_W]),
		.dyn_en       (remote_two_dyn_en),
		.period_valid (remote_two_period_valid),
		.dec_cycles   (remote_two_dec_cycles),
		.inc_cycles   (remote_two_inc_cycles)
	);

	assign loop_sel = tltc_loop_t'(cycle_ff[TLTC_LOOP_SEL_BIT]);
	assign loop_current = (loop_sel == TLTC_LOOP_CURRENT);

	assign reg_rdata                     = rdata_ff;
	assign first_thermal_limit_pin_o     = 1'b0;
	assign first_thermal_limit_pin_oe_n  = !drive1_ff;
	assign second_thermal_limit_pin_o    = 1'b0;
	assign second_thermal_limit_pin_oe_n = !drive2_ff;
	assign fan_max_pwm                   = fan_max_ff;
	assign first_timer_run               = run1_ff;
	assign first_timer_quarters          = win1_ff;
	assign second_timer_run              = run2_ff;
	assign second_timer_quarters         = win2_ff;
	assign first_pin_seen_low            = seen1_ff;
	assign second_pin_seen_low           = seen2_ff;
endmodule : tltc_top
`default_nettype wire

// File: dv/tltc_asserts.sv
// Concurrent checks on the thermal loop timing register bank ports.
// Assumes a bind onto tltc_top, seeing only its ports.
`timescale 1ns/1ps
`default_nettype none
module tltc_asserts (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic        sw_reset,
	input wire logic        reg_lock,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_rdata,
	input wire logic        first_over_limit,
	input wire logic        second_over_limit,
	input wire logic        first_thermal_limit_pin_oe_n,
	input wire logic        fan_max_pwm,
	input wire logic        loop_current,
	input wire logic        remote_one_dyn_en,
	input wire logic [11:0] remote_one_dec_cycles,
	input wire logic [11:0] remote_one_inc_cycles,
	input wire logic        first_timer_en,
	input wire logic [5:0]  first_timer_quarters
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_bit7_reads_zero:
	assert property (ce && reg_rd && reg_addr == 8'h0c |=> !reg_rdata[7]) else $error("reserved bit read as one");
	a_dec_in_range:
	assert property (ce && remote_one_dyn_en |=> $onehot(remote_one_dec_cycles) && remote_one_dec_cycles >= 12'h008
		&& remote_one_dec_cycles <= 12'h400) else $error("decrease period out of range");
	a_inc_twice_dec:
	assert property (ce |=> remote_one_inc_cycles == (remote_one_dec_cycles << 1)) else $error("increase not double");
	a_period_gated_off:
	assert property (ce && !remote_one_dyn_en |=> remote_one_dec_cycles == 12'h000) else $error("period without enable");
	a_pin_follows_limit:
	assert property (ce |=> first_thermal_limit_pin_oe_n == !$past(first_over_limit)) else $error("pin drive wrong");
	a_fan_idle_quiet:
	assert property (ce && !first_over_limit && !second_over_limit |=> !fan_max_pwm) else $error("boost without limit");
	a_timer_gated_off:
	assert property (ce && !first_timer_en |=> first_timer_quarters == 6'h00) else $error("window while timer off");
	a_window_in_range:
	assert property (ce && first_timer_en |=> $onehot(first_timer_quarters) && first_timer_quarters <= 6'h20)
		else $error("window out of range");
	a_lock_keeps_loop:
	assert property (ce && reg_wr && reg_lock && !sw_reset |=> $stable(loop_current)) else $error("locked write landed");
	a_swreset_loop:
	assert property (ce && sw_reset |=> loop_current) else $error("loop select not reset");
endmodule : tltc_asserts
bind tltc_top tltc_asserts u_asserts (.*);
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the thermal loop timing register bank.
// Assumes tltc_top and its bound checker; pins are pulled up on the board.
`timescale 1ns/1ps
`default_nettype none
module testbench import tltc_pkg::*;;
	logic ref_clk, resetn, ce, sw_reset, reg_lock, reg_wr, reg_rd, fan_max_pwm, loop_current;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic remote_one_dyn_en, remote_two_dyn_en, first_over_limit, second_over_limit, first_timer_en, second_timer_en;
	logic first_thermal_limit_pin_o, first_thermal_limit_pin_oe_n, first_pin_seen_low, first_timer_run;
	logic second_thermal_limit_pin_o, second_thermal_limit_pin_oe_n, second_pin_seen_low, second_timer_run;
	logic remote_one_period_valid, remote_two_period_valid;
	logic [11:0] remote_one_dec_cycles, remote_one_inc_cycles, remote_two_dec_cycles, remote_two_inc_cycles;
	logic [5:0] first_timer_quarters, second_timer_quarters;
	wire first_thermal_limit_pin_i = first_thermal_limit_pin_oe_n | first_thermal_limit_pin_o;
	wire second_thermal_limit_pin_i = second_thermal_limit_pin_oe_n | second_thermal_limit_pin_o;
	int errors, n_checks;
	tltc_top u_dut (.*);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string nm);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk({4'h0, reg_rdata}, {4'h0, exp}, nm);
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic t_cycle;
		logic [2:0] c;
		rd(TLTC_CYCLE_ADDR, 8'h40, "cycle reset");
		rd(TLTC_THERM_ADDR, 8'h00, "therm reset");
		rd(8'h0e, 8'h00, "unmapped");
		chk({11'h0, loop_current}, 12'h001, "loop default");
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(TLTC_CYCLE_ADDR, {2'b11, ~c, c});
			rd(TLTC_CYCLE_ADDR, {2'b01, ~c, c}, "cycle readback");
			settle();
			chk(remote_one_dec_cycles, 12'h008 << c, "r1 dec");
			chk(remote_one_inc_cycles, 12'h010 << c, "r1 inc");
			chk(remote_two_dec_cycles, 12'h008 << ~c, "r2 dec");
			chk(remote_two_inc_cycles, 12'h010 << ~c, "r2 inc");
		end
		chk({10'h0, remote_one_period_valid, remote_two_period_valid}, 12'h003, "periods valid");
		wr(TLTC_CYCLE_ADDR, 8'h00);
		@(posedge ref_clk) remote_one_dyn_en <= 1'b0;
		settle();
		chk({11'h0, loop_current}, 12'h000, "legacy loop");
		chk(remote_one_dec_cycles, 12'h000, "r1 gated");
		chk(remote_one_inc_cycles, 12'h000, "r1 inc gated");
		chk(remote_two_dec_cycles, 12'h008, "r2 still on");
		@(posedge ref_clk) remote_two_dyn_en <= 1'b0;
		settle();
		chk(remote_two_inc_cycles, 12'h000, "r2 gated");
		chk({10'h0, remote_one_period_valid, remote_two_period_valid}, 12'h000, "periods invalid");
	endtask : t_cycle
	task automatic t_therm;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(TLTC_THERM_ADDR, {~c, c, 2'b11});
			settle();
			chk({6'h0, first_timer_quarters}, 12'h001 << (c > 3'd5 ? 3'd5 : c), "win1");
			chk({6'h0, second_timer_quarters}, 12'h001 << (~c > 3'd5 ? 3'd5 : ~c), "win2");
		end
		for (int b = 0; b < 4; b++) begin
			wr(TLTC_THERM_ADDR, {6'h00, b[1:0]});
			@(posedge ref_clk) first_over_limit <= 1'b1;
			settle();
			chk({11'h0, fan_max_pwm}, {11'h0, ~b[0]}, "boost1");
			chk({11'h0, first_thermal_limit_pin_oe_n}, 12'h000, "pin1 drive");
			chk({11'h0, first_pin_seen_low}, 12'h001, "pin1 seen");
			@(posedge ref_clk) first_over_limit <= 1'b0;
			@(posedge ref_clk) second_over_limit <= 1'b1;
			settle();
			chk({11'h0, fan_max_pwm}, {11'h0, ~b[1]}, "boost2");
			chk({11'h0, second_thermal_limit_pin_oe_n}, 12'h000, "pin2 drive");
			chk({11'h0, second_pin_seen_low}, 12'h001, "pin2 seen");
			chk({10'h0, first_thermal_limit_pin_o, second_thermal_limit_pin_o}, 12'h000, "pin levels");
			@(posedge ref_clk) second_over_limit <= 1'b0;
		end
		chk({10'h0, first_timer_run, second_timer_run}, 12'h003, "timers run");
		@(posedge ref_clk) begin
			first_timer_en <= 1'b0;
			second_timer_en <= 1'b0;
		end
		settle();
		chk({6'h0, first_timer_quarters}, 12'h000, "timer off");
		chk({6'h0, second_timer_quarters}, 12'h000, "timer2 off");
		chk({10'h0, first_timer_run, second_timer_run}, 12'h000, "timers stop");
		chk({10'h0, first_thermal_limit_pin_oe_n, second_thermal_limit_pin_oe_n}, 12'h003, "pins released");
		chk({11'h0, fan_max_pwm}, 12'h000, "boost released");
	endtask : t_therm
	task automatic t_lock;
		wr(TLTC_CYCLE_ADDR, 8'h2a);
		@(posedge ref_clk) reg_lock <= 1'b1;
		wr(TLTC_CYCLE_ADDR, 8'h55);
		wr(TLTC_THERM_ADDR, 8'hff);
		rd(TLTC_CYCLE_ADDR, 8'h2a, "locked cycle");
		rd(TLTC_THERM_ADDR, 8'h03, "locked therm");
		@(posedge ref_clk) reg_lock <= 1'b0;
		// The write lands while software reset is still high, so the reload must win.
		@(posedge ref_clk) sw_reset <= 1'b1;
		wr(TLTC_CYCLE_ADDR, 8'h15);
		@(posedge ref_clk) sw_reset <= 1'b0;
		rd(TLTC_CYCLE_ADDR, 8'h40, "sw reset cycle");
		rd(TLTC_THERM_ADDR, 8'h00, "sw reset therm");
	endtask : t_lock
	task automatic t_ce;
		@(posedge ref_clk) ce <= 1'b0;
		wr(TLTC_CYCLE_ADDR, 8'h07);
		first_over_limit <= 1'b1;
		settle();
		chk({11'h0, fan_max_pwm}, 12'h000, "frozen boost");
		chk({11'h0, first_thermal_limit_pin_oe_n}, 12'h001, "frozen pin");
		@(posedge ref_clk) begin
			ce <= 1'b1;
			first_over_limit <= 1'b0;
		end
		rd(TLTC_CYCLE_ADDR, 8'h40, "frozen cycle");
	endtask : t_ce
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial begin
		{resetn, sw_reset, reg_lock, reg_wr, reg_rd, first_over_limit, second_over_limit} = 7'h00;
		{ce, remote_one_dyn_en, remote_two_dyn_en, first_timer_en, second_timer_en} = 5'h1f;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		t_cycle();
		t_therm();
		t_lock();
		t_ce();
		finish_test();
	end
	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
